// ### hw/opmode_pkg.sv
// Shared constants and types for the operating-mode and low-power controller
`default_nettype none
package opmode_pkg;
	// ------------------------------------------------------------
	// Register map: register index, byte address is index * 4
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_SLEEP = 8'h38;
	localparam logic [7:0] IDX_CLKHALT = 8'h39;
	localparam logic [7:0] IDX_WAKE = 8'h3A;
	localparam logic [7:0] IDX_STATUS = 8'h3B;
	localparam logic [7:0] IDX_NONE = 8'hFF;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_HI = 10;
	localparam logic [7:0] CLKHALT_RESET = 8'h80;
	localparam logic [7:0] SLEEP_RESET = 8'h00;
	localparam logic [7:0] CLKHALT_RD_MASK = 8'hF4;
	localparam logic [7:0] SLEEP_RD_MASK = 8'hFC;
	localparam int CH_SEL_BIT = 5;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int PC_W = 16;
	localparam logic [15:0] PC_STEP = 16'h0002;

	// ------------------------------------------------------------
	// Warm-up times (ms) and their cycle counts at the MCLK rate
	// ------------------------------------------------------------
	localparam real CLK_MHZ = 10.0;
	localparam real WARM_F0_MS = 12.288;
	localparam real WARM_F1_MS = 4.096;
	localparam real WARM_F2_MS = 3.072;
	localparam real WARM_F3_MS = 1.024;
	localparam real WARM_S0_MS = 750.0;
	localparam real WARM_S1_MS = 250.0;
	localparam real WARM_S2_MS = 5.85;
	localparam real WARM_S3_MS = 1.95;
	localparam int WARM_F0_CYC = int'($ceil(WARM_F0_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_F1_CYC = int'($ceil(WARM_F1_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_F2_CYC = int'($ceil(WARM_F2_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_F3_CYC = int'($ceil(WARM_F3_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_S0_CYC = int'($ceil(WARM_S0_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_S1_CYC = int'($ceil(WARM_S1_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_S2_CYC = int'($ceil(WARM_S2_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_S3_CYC = int'($ceil(WARM_S3_MS * 1.0e3 * CLK_MHZ));
	localparam int WARM_W = 24;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_CPU_HALT,
		MODE_BASE_HALT,
		MODE_STOP,
		MODE_WARMUP
	} mode_t;

	typedef struct packed {
		logic fast_osc_enable;
		logic slow_osc_enable;
		logic clock_select;
		logic cpu_halt_request;
		logic rsv3;
		logic peripheral_clock_gate;
		logic [1:0] rsv10;
	} clock_and_halt_control_t;

	typedef struct packed {
		logic stop_start;
		logic release_select;
		logic return_target;
		logic output_hold;
		logic [1:0] warmup_select;
		logic [1:0] rsv10;
	} deep_sleep_control_t;

	typedef struct packed {
		logic clock_fault_rst;
		logic cpu_halt;
		logic periph_gate;
		logic core_stop;
		logic divider_clear;
		logic fast_osc_on;
		logic slow_osc_on;
		logic sys_clk_slow;
		logic port_hold;
	} power_out_t;
endpackage : opmode_pkg
`default_nettype wire

// ### hw/pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t st;
	sync_t next_st;

	// ------------------------------------------------------------
	// Stage one feeds only stage two; the output moves per bit when 2 and 3 match
	// ------------------------------------------------------------
	always_comb begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign dout = st.q;
endmodule : pin_sync
`default_nettype wire

// ### hw/warmup_timer.sv
// Down-counter that times the oscillator warm-up after deep stop
`default_nettype none
module warmup_timer #(
	parameter int W = opmode_pkg::WARM_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [W-1:0] len,
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [W-1:0] cnt;
	} warm_t;

	warm_t st;
	warm_t next_st;

	// ------------------------------------------------------------
	// Load on start, count down, one-cycle done when the last cycle passes
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.busy = 1'b1;
			next_st.cnt = len;
		end else if (st.busy) begin
			if (st.cnt <= W'(1)) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt - W'(1);
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign done = st.done;
endmodule : warmup_timer
`default_nettype wire

// ### hw/opmode_ctrl.sv
// Operating-mode, halt and deep stop controller with an AHB-Lite register slave
`default_nettype none
module opmode_ctrl #(
	parameter int KEYS = 4,
	parameter int WARM_F0 = opmode_pkg::WARM_F0_CYC,
	parameter int WARM_F1 = opmode_pkg::WARM_F1_CYC,
	parameter int WARM_F2 = opmode_pkg::WARM_F2_CYC,
	parameter int WARM_F3 = opmode_pkg::WARM_F3_CYC,
	parameter int WARM_S0 = opmode_pkg::WARM_S0_CYC,
	parameter int WARM_S1 = opmode_pkg::WARM_S1_CYC,
	parameter int WARM_S2 = opmode_pkg::WARM_S2_CYC,
	parameter int WARM_S3 = opmode_pkg::WARM_S3_CYC
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic RELEASE_PIN,
	input wire logic [KEYS-1:0] KEY_WAKE,
	input wire logic TB_SRC,
	input wire logic CPU_HALT_RELEASE,
	input wire logic [opmode_pkg::PC_W-1:0] INSTR_ADDR,
	output logic [opmode_pkg::PC_W-1:0] RESUME_ADDR,
	output var opmode_pkg::power_out_t PWR
);
	localparam int WW = opmode_pkg::WARM_W;

	typedef struct packed {
		opmode_pkg::clock_and_halt_control_t clk_halt;
		opmode_pkg::deep_sleep_control_t deep_sleep;
		logic [KEYS-1:0] wake;
		logic [KEYS-1:0] key_prev;
		logic rel_prev;
		logic tb_prev;
		opmode_pkg::mode_t mode;
		logic pend_wr;
		logic [7:0] idx;
		logic [31:0] rdata;
		logic [opmode_pkg::PC_W-1:0] resume;
		opmode_pkg::power_out_t out;
	} ctl_t;

	ctl_t st;
	ctl_t nx;
	opmode_pkg::clock_and_halt_control_t wclk;
	opmode_pkg::deep_sleep_control_t wslp;
	logic [KEYS-1:0] key_s;
	logic rel_s;
	logic tb_s;
	logic key_hit;
	logic fault;
	logic take;
	logic [7:0] a_idx;
	logic [7:0] rd8;
	logic warm_start;
	logic warm_done;
	logic [WW-1:0] warm_len;

	// ------------------------------------------------------------
	// Pin synchronisers and warm-up counter
	// ------------------------------------------------------------
	pin_sync #(
		.W(KEYS + 2)
	) u_sync (
		.clk(MCLK),
		.rst_n(ARST_N),
		.ce(CE),
		.din({TB_SRC, RELEASE_PIN, KEY_WAKE}),
		.dout({tb_s, rel_s, key_s})
	);

	warmup_timer #(
		.W(WW)
	) u_warm (
		.clk(MCLK),
		.rst_n(ARST_N),
		.ce(CE),
		.start(warm_start),
		.len(warm_len),
		.busy(),
		.done(warm_done)
	);

	// Address phase decode; anything outside the map gets an index nobody owns
	assign take = HSEL && HTRANS[1] && HREADY;
	assign a_idx = (HADDR[31:opmode_pkg::ADDR_HI] == '0) ?
		HADDR[opmode_pkg::ADDR_LSB +: 8] : opmode_pkg::IDX_NONE;
	assign wclk = opmode_pkg::clock_and_halt_control_t'(HWDATA[7:0]);
	assign wslp = opmode_pkg::deep_sleep_control_t'(HWDATA[7:0]);
	// Oscillator combination that would leave the system without a clock
	assign fault = (!wclk.fast_osc_enable && !wclk.slow_osc_enable) ||
		(!wclk.fast_osc_enable && !wclk.clock_select) ||
		(!wclk.slow_osc_enable && wclk.clock_select);
	assign key_hit = |((key_s ^ st.key_prev) & st.wake);

	// ------------------------------------------------------------
	// Next-state logic: hardware events first, then the bus write; a write sets halt or stop
	// requests only from run mode, so a hardware clear in the same cycle is kept
	// ------------------------------------------------------------
	always_comb begin
		nx = st;
		nx.out.clock_fault_rst = 1'b0;
		warm_start = 1'b0;
		rd8 = '0;
		nx.key_prev = key_s;
		nx.rel_prev = rel_s;
		nx.tb_prev = tb_s;
		case (st.mode)
			opmode_pkg::MODE_CPU_HALT: begin
				if (CPU_HALT_RELEASE) begin
					nx.mode = opmode_pkg::MODE_RUN;
					nx.clk_halt.cpu_halt_request = 1'b0;
				end
			end
			opmode_pkg::MODE_BASE_HALT: begin
				// Falling edge of the time-base source; the source is free running
				// so the first period may be short
				if (st.tb_prev && !tb_s) begin
					nx.mode = opmode_pkg::MODE_RUN;
					nx.clk_halt.peripheral_clock_gate = 1'b0;
				end
			end
			opmode_pkg::MODE_STOP: begin
				// Edge mode looks at the pin only; keys count in level mode
				if (st.deep_sleep.release_select ? (rel_s || key_hit)
					: (rel_s && !st.rel_prev)) begin
					nx.mode = opmode_pkg::MODE_WARMUP;
					warm_start = 1'b1;
				end
			end
			opmode_pkg::MODE_WARMUP: begin
				if (warm_done) begin
					nx.mode = opmode_pkg::MODE_RUN;
					nx.deep_sleep.stop_start = 1'b0;
					nx.clk_halt.clock_select = st.deep_sleep.return_target;
					nx.out.sys_clk_slow = st.deep_sleep.return_target;
					if (st.deep_sleep.return_target) begin
						nx.clk_halt.fast_osc_enable = 1'b0;
					end
				end
			end
			default: begin
			end
		endcase

		// Data phase of a write
		if (st.pend_wr) begin
			if (st.idx == opmode_pkg::IDX_CLKHALT) begin
				if (fault) begin
					// Reset request also returns both control registers, the mode and the clock select to their reset values
					nx.out.clock_fault_rst = 1'b1;
					nx.clk_halt = opmode_pkg::CLKHALT_RESET;
					nx.deep_sleep = opmode_pkg::SLEEP_RESET;
					nx.mode = opmode_pkg::MODE_RUN;
					nx.out.sys_clk_slow = 1'b0;
				end else begin
					nx.clk_halt.fast_osc_enable = wclk.fast_osc_enable;
					nx.clk_halt.slow_osc_enable = wclk.slow_osc_enable;
					nx.clk_halt.clock_select = wclk.clock_select;
					nx.out.sys_clk_slow = wclk.clock_select;
					if (wclk.cpu_halt_request && wclk.peripheral_clock_gate) begin
						// Forbidden pair: both requests are dropped
						nx.clk_halt.cpu_halt_request = 1'b0;
						nx.clk_halt.peripheral_clock_gate = 1'b0;
					end else if (st.mode == opmode_pkg::MODE_RUN) begin
						nx.clk_halt.cpu_halt_request = wclk.cpu_halt_request;
						nx.clk_halt.peripheral_clock_gate = wclk.peripheral_clock_gate;
						if (wclk.cpu_halt_request) begin
							nx.mode = opmode_pkg::MODE_CPU_HALT;
							nx.resume = INSTR_ADDR + opmode_pkg::PC_STEP;
						end else if (wclk.peripheral_clock_gate) begin
							nx.mode = opmode_pkg::MODE_BASE_HALT;
							nx.resume = INSTR_ADDR + opmode_pkg::PC_STEP;
						end
					end
				end
			end else if (st.idx == opmode_pkg::IDX_SLEEP) begin
				nx.deep_sleep = wslp & opmode_pkg::SLEEP_RD_MASK;
				nx.deep_sleep.stop_start = 1'b0;
				if (wslp.stop_start && st.mode == opmode_pkg::MODE_RUN) begin
					nx.deep_sleep.stop_start = 1'b1;
					nx.resume = INSTR_ADDR + opmode_pkg::PC_STEP;
					// Pin already high in level mode: skip the stop itself
					if (wslp.release_select && rel_s) begin
						nx.mode = opmode_pkg::MODE_WARMUP;
						warm_start = 1'b1;
					end else begin
						nx.mode = opmode_pkg::MODE_STOP;
					end
				end
			end else if (st.idx == opmode_pkg::IDX_WAKE) begin
				nx.wake = HWDATA[KEYS-1:0];
			end
		end

		// Warm-up length from the settings that govern this release
		case (nx.deep_sleep.warmup_select)
			2'h0: warm_len = nx.deep_sleep.return_target ? WW'(WARM_S0) : WW'(WARM_F0);
			2'h1: warm_len = nx.deep_sleep.return_target ? WW'(WARM_S1) : WW'(WARM_F1);
			2'h2: warm_len = nx.deep_sleep.return_target ? WW'(WARM_S2) : WW'(WARM_F2);
			default: warm_len = nx.deep_sleep.return_target ? WW'(WARM_S3) : WW'(WARM_F3);
		endcase

		// Outputs follow the new mode so pins and mode change on the same edge
		nx.out.cpu_halt = (nx.mode != opmode_pkg::MODE_RUN);
		nx.out.periph_gate = (nx.mode == opmode_pkg::MODE_BASE_HALT);
		nx.out.core_stop = (nx.mode == opmode_pkg::MODE_STOP) ||
			(nx.mode == opmode_pkg::MODE_WARMUP);
		nx.out.divider_clear = (nx.mode == opmode_pkg::MODE_STOP);
		nx.out.port_hold = nx.out.core_stop && nx.deep_sleep.output_hold;
		if (nx.mode == opmode_pkg::MODE_STOP) begin
			nx.out.fast_osc_on = 1'b0;
			nx.out.slow_osc_on = 1'b0;
		end else if (nx.mode == opmode_pkg::MODE_WARMUP) begin
			// Slow restarts if enabled; fast restarts unless slow is enabled and the target is slow
			nx.out.slow_osc_on = nx.clk_halt.slow_osc_enable;
			nx.out.fast_osc_on = !(nx.clk_halt.slow_osc_enable &&
				nx.deep_sleep.return_target);
		end else begin
			nx.out.fast_osc_on = nx.clk_halt.fast_osc_enable;
			nx.out.slow_osc_on = nx.clk_halt.slow_osc_enable;
		end

		// Address phase; read data comes from the values after this cycle's write
		nx.pend_wr = take && HWRITE;
		nx.idx = take ? a_idx : opmode_pkg::IDX_NONE;
		if (take && !HWRITE) begin
			if (a_idx == opmode_pkg::IDX_SLEEP) begin
				nx.rdata = 32'(nx.deep_sleep & opmode_pkg::SLEEP_RD_MASK);
			end else if (a_idx == opmode_pkg::IDX_CLKHALT) begin
				rd8 = nx.clk_halt & opmode_pkg::CLKHALT_RD_MASK;
				rd8[opmode_pkg::CH_SEL_BIT] = nx.out.sys_clk_slow;
				nx.rdata = 32'(rd8);
			end else if (a_idx == opmode_pkg::IDX_WAKE) begin
				nx.rdata = 32'(nx.wake);
			end else if (a_idx == opmode_pkg::IDX_STATUS) begin
				nx.rdata = 32'({key_s, rel_s, nx.mode});
			end else begin
				nx.rdata = '0;
			end
		end
	end

	// ------------------------------------------------------------
	// State register; reset lands in fast single run
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st <= '0;
			st.clk_halt <= opmode_pkg::CLKHALT_RESET;
			st.deep_sleep <= opmode_pkg::SLEEP_RESET;
			st.idx <= opmode_pkg::IDX_NONE;
			st.out.fast_osc_on <= 1'b1; // Fast single run keeps its oscillator through reset
		end else if (CE) begin
			st <= nx;
		end
	end

	assign HRDATA = st.rdata;
	assign HREADYOUT = CE; // Wait states only while frozen
	assign HRESP = opmode_pkg::HRESP_OKAY;
	assign RESUME_ADDR = st.resume;
	assign PWR = st.out;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!ARST_N);

	sequence s_wr_clkhalt;
		CE && st.pend_wr && st.idx == opmode_pkg::IDX_CLKHALT;
	endsequence
	sequence s_wr_sleep;
		CE && st.pend_wr && st.idx == opmode_pkg::IDX_SLEEP;
	endsequence
	sequence s_run_ok;
		st.mode == opmode_pkg::MODE_RUN && !fault;
	endsequence

	property p_clk_fault;
		s_wr_clkhalt ##0 fault |=> PWR.clock_fault_rst ##1 !PWR.clock_fault_rst;
	endproperty
	a_clk_fault: assert property (p_clk_fault) else $error("no reset on bad oscillator write");
	property p_sel_read;
		CE && take && !HWRITE && a_idx == opmode_pkg::IDX_CLKHALT
			|=> HRDATA[opmode_pkg::CH_SEL_BIT] == PWR.sys_clk_slow;
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("clock select read mismatch");

	property p_cpu_halt;
		s_wr_clkhalt ##0 s_run_ok ##0 (wclk.cpu_halt_request && !wclk.peripheral_clock_gate)
			|=> PWR.cpu_halt && !PWR.periph_gate && st.mode == opmode_pkg::MODE_CPU_HALT;
	endproperty
	a_cpu_halt: assert property (p_cpu_halt) else $error("cpu halt not entered");

	property p_gate;
		s_wr_clkhalt ##0 s_run_ok ##0 (!wclk.cpu_halt_request && wclk.peripheral_clock_gate)
			|=> PWR.periph_gate && PWR.cpu_halt;
	endproperty
	a_gate: assert property (p_gate) else $error("peripheral gate not entered");

	property p_halt_clear;
		CE && st.mode == opmode_pkg::MODE_CPU_HALT && CPU_HALT_RELEASE && !st.pend_wr
			|=> !st.clk_halt.cpu_halt_request && !PWR.cpu_halt;
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt bit not cleared");

	property p_stop_osc;
		st.mode == opmode_pkg::MODE_STOP |-> !PWR.fast_osc_on && !PWR.slow_osc_on;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("oscillator on in stop");

	property p_stop_div;
		st.mode == opmode_pkg::MODE_STOP |-> PWR.divider_clear && PWR.core_stop;
	endproperty
	a_stop_div: assert property (p_stop_div) else $error("divider not cleared in stop");

	property p_resume;
		s_wr_clkhalt ##0 s_run_ok ##0 (wclk.cpu_halt_request && !wclk.peripheral_clock_gate)
			|=> RESUME_ADDR == 16'($past(INSTR_ADDR) + opmode_pkg::PC_STEP);
	endproperty
	a_resume: assert property (p_resume) else $error("resume address wrong");

	property p_level_hot;
		s_wr_sleep ##0 (st.mode == opmode_pkg::MODE_RUN && wslp.stop_start &&
			wslp.release_select && rel_s) |=> st.mode == opmode_pkg::MODE_WARMUP;
	endproperty
	a_level_hot: assert property (p_level_hot) else $error("stop entered with pin high");

	property p_level_rel;
		CE && st.mode == opmode_pkg::MODE_STOP && st.deep_sleep.release_select && rel_s
			|=> st.mode == opmode_pkg::MODE_WARMUP ##0 PWR.core_stop;
	endproperty
	a_level_rel: assert property (p_level_rel) else $error("level release missed");

	property p_ret_slow;
		CE && st.mode == opmode_pkg::MODE_WARMUP && warm_done && st.deep_sleep.return_target
			|=> st.mode == opmode_pkg::MODE_RUN && PWR.sys_clk_slow && !PWR.fast_osc_on;
	endproperty
	a_ret_slow: assert property (p_ret_slow) else $error("slow return wrong");
endmodule : opmode_ctrl
`default_nettype wire

// ### testbench/stop_pin_model.sv
// Model of the stop-release pin and key wake inputs at the block's far side
`default_nettype none
module stop_pin_model (
	input wire logic clk,
	output logic pin,
	output logic [3:0] keys
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins start low so that no release is pending out of reset
	initial begin
		pin = 1'b0;
		keys = 4'h0;
	end
	// Pin level moves just after an edge; software reads it back before stopping
	task automatic set_pin(input logic v);
		@(posedge clk);
		pin <= v;
	endtask : set_pin
	// Keys are only flipped while level release is selected
	task automatic flip_key(input int i);
		@(posedge clk);
		keys[i] <= ~keys[i];
	endtask : flip_key
endmodule : stop_pin_model
`default_nettype wire

// ### testbench/operating_mode_power_control_bench.sv
// Self-checking bench for the operating-mode and power controller
`default_nettype none
module operating_mode_power_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WF[4] = '{40, 30, 20, 10};
	localparam int WS0 = 80;
	localparam logic [31:0] A_SLP = 32'(opmode_pkg::IDX_SLEEP) << 2;
	localparam logic [31:0] A_CH = 32'(opmode_pkg::IDX_CLKHALT) << 2;
	localparam logic [31:0] A_WAK = 32'(opmode_pkg::IDX_WAKE) << 2;
	localparam logic [31:0] A_ST = 32'(opmode_pkg::IDX_STATUS) << 2;
	localparam int CPH = 7, PG = 6, CS = 5, DC = 4, SL = 1;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] hsize = 3'h0;
	logic ce = 1'b1;
	logic tb_src = 1'b0;
	logic halt_rel = 1'b0;
	logic [15:0] instr_addr = 16'h1234;
	logic [31:0] hrdata;
	logic hreadyout, hresp, rel_pin;
	logic [3:0] keys;
	logic [15:0] resume_addr;
	opmode_pkg::power_out_t pwr;
	wire logic [8:0] pw = pwr;
	int error_cnt = 0, checked = 0, wcnt = 0, fcnt = 0, dcnt = 0;
	always #50 mclk = ~mclk;
	// Count warm-up cycles, stop cycles and fault pulses on the sampling edge
	always @(posedge mclk) begin
		if (pw[CS] === 1'b1 && pw[DC] === 1'b0)
			wcnt++;
		if (pw[DC] === 1'b1)
			dcnt++;
		if (pw[8] === 1'b1)
			fcnt++;
	end
	opmode_ctrl #(.WARM_F0(WF[0]), .WARM_F1(WF[1]), .WARM_F2(WF[2]), .WARM_F3(WF[3]),
		.WARM_S0(WS0)) u_opmode_ctrl (.MCLK(mclk), .ARST_N(arst_n), .CE(ce),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .RELEASE_PIN(rel_pin), .KEY_WAKE(keys), .TB_SRC(tb_src),
		.CPU_HALT_RELEASE(halt_rel), .INSTR_ADDR(instr_addr), .RESUME_ADDR(resume_addr),
		.PWR(pwr));
	stop_pin_model u_stop_pin_model (.clk(mclk), .pin(rel_pin), .keys(keys));
	task automatic final_report;
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait for the slave's ready; a hang ends the run
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			final_report();
		end
	endtask : rdy
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r, e);
		chk(32'(hresp), 32'h0);
	endtask : rd
	// Poll one power output at mid-cycle, giving up after a fixed bound
	task automatic wait_pw(input int b, input logic v);
		int n;
		n = 0;
		while (pw[b] !== v && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		chk(32'(pw[b]), 32'(v));
		if (n >= 2000)
			final_report();
	endtask : wait_pw
	task automatic t_reset;
		rd(A_CH, 32'h80);
		rd(A_SLP, 32'h0);
		rd(32'h100, 32'h0);
		chk(32'(pw), 32'h8);
	endtask : t_reset
	task automatic t_clock;
		wr(A_CH, 32'hE0);
		wait_pw(SL, 1'b1);
		rd(A_CH, 32'hE0);
		wr(A_CH, 32'hC0);
		wait_pw(SL, 1'b0);
	endtask : t_clock
	// Three of the four illegal oscillator combinations each pulse once and restore the register
	task automatic t_fault;
		logic [31:0] bad[3] = '{32'h40, 32'h00, 32'hA0};
		foreach (bad[i]) begin
			fcnt = 0;
			wr(A_CH, bad[i]);
			repeat (4) @(negedge mclk);
			chk(32'(fcnt), 32'h1);
			rd(A_CH, 32'h80);
		end
	endtask : t_fault
	task automatic t_halts;
		wr(A_CH, 32'h90);
		wait_pw(CPH, 1'b1);
		chk(32'(resume_addr), 32'h1236);
		// A release that arrives while the clock enable is low must be lost
		@(posedge mclk);
		ce <= 1'b0;
		halt_rel <= 1'b1;
		@(posedge mclk);
		halt_rel <= 1'b0;
		@(negedge mclk);
		chk(32'({hreadyout, pw[CPH]}), 32'h1);
		@(posedge mclk);
		ce <= 1'b1;
		halt_rel <= 1'b1;
		@(posedge mclk);
		halt_rel <= 1'b0;
		wait_pw(CPH, 1'b0);
		rd(A_CH, 32'h80);
		wr(A_CH, 32'h84);
		wait_pw(PG, 1'b1);
		@(posedge mclk);
		tb_src <= 1'b1;
		repeat (6) @(posedge mclk);
		tb_src <= 1'b0;
		wait_pw(PG, 1'b0);
		rd(A_CH, 32'h80);
	endtask : t_halts
	task automatic t_stop_edge;
		instr_addr <= 16'h2000;
		wr(A_SLP, 32'h80);
		wait_pw(CS, 1'b1);
		chk(32'(pw[4:2]), 32'h4);
		chk(32'(resume_addr), 32'h2002);
		u_stop_pin_model.set_pin(1'b1);
		wait_pw(CS, 1'b0);
		rd(A_SLP, 32'h0);
		u_stop_pin_model.set_pin(1'b0);
	endtask : t_stop_edge
	// Pin already high: every code goes straight to warm-up of its own length
	task automatic t_warm;
		u_stop_pin_model.set_pin(1'b1);
		// Let the pin pass the synchroniser before reading it back
		repeat (4) @(posedge mclk);
		rd(A_ST, 32'h8);
		for (int k = 0; k < 4; k++) begin
			wcnt = 0;
			dcnt = 0;
			wr(A_SLP, 32'(32'hC0 | (k << 2)));
			@(negedge mclk);
			chk(32'(pw[3:2]), 32'h2);
			wait_pw(CS, 1'b0);
			chk(32'(wcnt >= WF[k] && wcnt <= WF[k] + 3 && dcnt == 0), 32'h1);
		end
		wcnt = 0;
		wr(A_CH, 32'hC0);
		wr(A_SLP, 32'hE0);
		@(negedge mclk);
		chk(32'(pw[3:2]), 32'h1);
		wait_pw(CS, 1'b0);
		chk(32'(wcnt >= WS0 && wcnt <= WS0 + 3), 32'h1);
		wait_pw(SL, 1'b1);
		wr(A_CH, 32'hC0);
		wait_pw(SL, 1'b0);
		u_stop_pin_model.set_pin(1'b0);
	endtask : t_warm
	// Only an enabled key releases; a disabled one leaves the stop standing
	task automatic t_key;
		wr(A_WAK, 32'h1);
		rd(A_ST, 32'h0);
		wr(A_SLP, 32'hCC);
		wait_pw(CS, 1'b1);
		u_stop_pin_model.flip_key(1);
		repeat (8) @(posedge mclk);
		rd(A_ST, 32'h23);
		u_stop_pin_model.flip_key(0);
		wait_pw(CS, 1'b0);
	endtask : t_key
	task automatic t_reset_pin;
		wr(A_SLP, 32'hC0);
		wait_pw(CS, 1'b1);
		@(posedge mclk);
		arst_n <= 1'b0;
		@(negedge mclk);
		chk(32'(pw), 32'h8);
		@(posedge mclk);
		arst_n <= 1'b1;
		rd(A_SLP, 32'h0);
	endtask : t_reset_pin
	// Main sequence
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_clock();
		t_fault();
		t_halts();
		t_stop_edge();
		t_warm();
		t_key();
		t_reset_pin();
		final_report();
	end
endmodule : operating_mode_power_control_bench
`default_nettype wire
